// ---- config_word_readback_verify.sv ----
// Serial programming port: instruction execution and visibility readout
`timescale 1ns/100ps
`include "config_readback_consts.svh"

module config_word_readback_verify #(
  parameter logic [15:0] CW_FIRST = `CRV_CFG_DEFAULT,
  parameter logic [15:0] CW_SECOND = `CRV_CFG_DEFAULT,
  parameter logic [15:0] CW_THIRD = `CRV_CFG_DEFAULT,
  parameter logic [15:0] CW_FOURTH = `CRV_CFG_DEFAULT,
  // Arbitrary value standing for the resident-executive signature
  parameter logic [15:0] SIGNATURE = `CRV_SIG_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Programming link
  input wire logic prog_clk,
  input wire logic prog_data_in,
  output logic prog_data_out,
  output logic prog_data_oe,
  // Status
  output logic [15:0] serial_visibility_out,
  output logic [15:0] exec_pc,
  output logic read_protected
);

  logic pclk_meta_reg;
  logic pclk_sync_reg;
  logic pclk_prev_reg;
  logic pdat_meta_reg;
  logic pdat_sync_reg;
  logic rise;
  logic fall;

  config_readback_pkg::port_state_e state_reg;
  config_readback_pkg::port_state_e state_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [15:0] out_shift_reg;
  logic [15:0] out_shift_next;
  logic dout_reg;
  logic dout_next;
  logic oe_reg;
  logic oe_next;
  logic [15:0] vis_reg;
  logic [15:0] vis_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [7:0] table_page_reg;
  logic [7:0] table_page_next;
  logic [15:0] w_reg [16];
  logic [15:0] w_next [16];
  logic protect_q_reg;

  logic [23:0] instr;
  logic [3:0] cmd_code;
  logic exec_go;
  logic [23:0] rd_addr;
  logic [23:0] rd_word;
  logic protect_now;
  logic tblrd_vis;

  // Link pins pass two flops; data is taken from the second, the clock from the second and a third flop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pclk_meta_reg <= 1'b0;
      pclk_sync_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
      pdat_meta_reg <= 1'b0;
      pdat_sync_reg <= 1'b0;
    end
    else
    begin
      pclk_meta_reg <= prog_clk;
      pclk_sync_reg <= pclk_meta_reg;
      pclk_prev_reg <= pclk_sync_reg;
      pdat_meta_reg <= prog_data_in;
      pdat_sync_reg <= pdat_meta_reg;
    end
  end

  assign rise = pclk_sync_reg & ~pclk_prev_reg;
  assign fall = ~pclk_sync_reg & pclk_prev_reg;

  // Payload and command arrive least significant bit first
  assign instr = {pdat_sync_reg, shift_reg[23:1]};
  assign cmd_code = instr[23:20];
  assign exec_go = (state_reg == config_readback_pkg::ST_EXEC) && rise
    && (cnt_reg == `CRV_INSTR_LAST);

  // Table read source: table_page above the source working register
  assign rd_addr = {table_page_reg, w_reg[instr[3:0]]};
  assign tblrd_vis = exec_go && (instr[23:14] == `CRV_OP_TABLE_READ_LOW)
    && (w_reg[instr[10:7]] == `CRV_VISIBILITY_ADDR);

  config_store #(
    .CW_FIRST(CW_FIRST),
    .CW_SECOND(CW_SECOND),
    .CW_THIRD(CW_THIRD),
    .CW_FOURTH(CW_FOURTH),
    .SIGNATURE(SIGNATURE)
  ) config_store_i (
    .clk(clk),
    .reset(reset),
    .rd_addr(rd_addr),
    .rd_word(rd_word),
    .read_protected(protect_now)
  );

  function automatic logic is_postinc(input logic [2:0] mode);
    return mode == `CRV_MODE_POSTINC;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    out_shift_next = out_shift_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    vis_next = vis_reg;
    pc_next = pc_reg;
    table_page_next = table_page_reg;
    w_next = w_reg;
    unique case (state_reg)
      config_readback_pkg::ST_CMD:
      begin
        if (rise)
        begin
          shift_next = instr;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `CRV_CMD_LAST)
          begin
            cnt_next = 5'h00;
            if (cmd_code == `CRV_CMD_READOUT)
            begin
              state_next = config_readback_pkg::ST_OUT;
              oe_next = 1'b1;
              dout_next = vis_reg[0];
              out_shift_next = vis_reg;
            end
            else if (cmd_code == `CRV_CMD_EXEC)
              state_next = config_readback_pkg::ST_EXEC;
            else
              state_next = config_readback_pkg::ST_SKIP;
          end
        end
      end
      config_readback_pkg::ST_EXEC,
      config_readback_pkg::ST_SKIP:
      begin
        // Unknown commands still swallow a 24-bit payload to stay framed
        if (rise)
        begin
          shift_next = instr;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `CRV_INSTR_LAST)
          begin
            cnt_next = 5'h00;
            state_next = config_readback_pkg::ST_CMD;
          end
        end
      end
      config_readback_pkg::ST_OUT:
      begin
        // Device changes data on falling edges; the programmer samples on rising
        if (rise)
        begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `CRV_OUT_LAST)
          begin
            cnt_next = 5'h00;
            oe_next = 1'b0;
            state_next = config_readback_pkg::ST_CMD;
          end
        end
        else if (fall)
        begin
          // The rise that closes the command already drives bit 0; the first fall here drives bit 0 again, then each fall drives the next bit
          out_shift_next = {1'b0, out_shift_reg[15:1]};
          dout_next = out_shift_reg[0];
        end
      end
    endcase

    if (exec_go)
    begin
      if (instr[23:16] == `CRV_OP_GOTO)
        pc_next = instr[15:0];
      else if (instr[23:20] == `CRV_OP_MOVLIT)
        w_next[instr[3:0]] = instr[19:4];
      else if (instr[23:19] == `CRV_OP_MOVWF)
      begin
        if ({instr[18:4], 1'b0} == `CRV_VISIBILITY_ADDR)
          vis_next = w_reg[instr[3:0]];
        else if ({instr[18:4], 1'b0} == `CRV_TABLE_PAGE_ADDR)
          table_page_next = w_reg[instr[3:0]][7:0];
      end
      else if (instr[23:14] == `CRV_OP_TABLE_READ_LOW)
      begin
        // Only the low 16 bits are moved, so configuration words lose no data
        if (instr[13:11] == `CRV_MODE_IND || is_postinc(instr[13:11]))
        begin
          if (w_reg[instr[10:7]] == `CRV_VISIBILITY_ADDR)
            vis_next = rd_word[15:0];
        end
        if (is_postinc(instr[6:4]))
          w_next[instr[3:0]] = w_reg[instr[3:0]] + 16'h0002;
        if (is_postinc(instr[13:11]) && instr[10:7] != instr[3:0])
          w_next[instr[10:7]] = w_reg[instr[10:7]] + 16'h0002;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= config_readback_pkg::ST_CMD;
      cnt_reg <= 5'h00;
      shift_reg <= 24'h000000;
      out_shift_reg <= `CRV_WORD_RESET;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      vis_reg <= `CRV_WORD_RESET;
      pc_reg <= `CRV_WORD_RESET;
      table_page_reg <= `CRV_PAGE_RESET;
      w_reg <= '{default: `CRV_WORD_RESET};
      protect_q_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      out_shift_reg <= out_shift_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      vis_reg <= vis_next;
      pc_reg <= pc_next;
      table_page_reg <= table_page_next;
      w_reg <= w_next;
      protect_q_reg <= protect_now;
    end
  end

  assign prog_data_out = dout_reg;
  assign prog_data_oe = oe_reg;
  assign serial_visibility_out = vis_reg;
  assign exec_pc = pc_reg;
  assign read_protected = protect_q_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  readout_start_a: assert property (
    (state_reg == config_readback_pkg::ST_CMD && rise && cnt_reg == `CRV_CMD_LAST
      && cmd_code == `CRV_CMD_READOUT)
    |=> oe_reg && dout_reg == $past(vis_reg[0])) else $error("readout did not start");
  readout_drive_a: assert property (
    (state_reg == config_readback_pkg::ST_OUT) |-> oe_reg) else $error("readout not driven");
  cmd_quiet_a: assert property (
    (state_reg != config_readback_pkg::ST_OUT) |-> !oe_reg) else $error("driving outside readout");
  frame_count_a: assert property (
    (state_reg == config_readback_pkg::ST_CMD) |-> cnt_reg <= `CRV_CMD_LAST)
    else $error("command count overrun");
  tblrd_load_a: assert property (
    (tblrd_vis && instr[13:11] == `CRV_MODE_IND)
    |=> vis_reg == $past(rd_word[15:0])) else $error("table read did not load register");
  postinc_a: assert property (
    (exec_go && instr[23:14] == `CRV_OP_TABLE_READ_LOW && is_postinc(instr[6:4])
      && instr[10:7] != instr[3:0])
    |=> w_reg[$past(instr[3:0])] == $past(w_reg[instr[3:0]]) + 16'h0002)
    else $error("read pointer not advanced");
  exec_only_a: assert property (
    (state_reg == config_readback_pkg::ST_SKIP) |=> $stable(vis_reg))
    else $error("skipped payload changed register");
  shift_bit_a: assert property (
    (state_reg == config_readback_pkg::ST_OUT && fall && !rise)
    |=> dout_reg == $past(out_shift_reg[0])) else $error("wrong readout bit");

  readout_c: cover property (state_reg == config_readback_pkg::ST_OUT
    && rise && cnt_reg == `CRV_OUT_LAST);
  tblrd_c: cover property (tblrd_vis);
  goto_c: cover property (exec_go && instr[23:16] == `CRV_OP_GOTO);

endmodule

// ---- config_readback_consts.svh ----
// Constants of the serial configuration readback port
`ifndef CONFIG_READBACK_CONSTS_SVH
`define CONFIG_READBACK_CONSTS_SVH

// Four-bit command codes
`define CRV_CMD_EXEC 4'h0
`define CRV_CMD_READOUT 4'h1

// Frame lengths in link clock bits, given as last-bit indices
`define CRV_CMD_LAST 5'h03
`define CRV_INSTR_LAST 5'h17
`define CRV_OUT_LAST 5'h0F

// Data space addresses of the special registers
`define CRV_VISIBILITY_ADDR 16'h0784
`define CRV_TABLE_PAGE_ADDR 16'h0032

// Program space addresses
`define CRV_SIG_ADDR 24'h8007F0
`define CRV_CFG_BASE 24'h000100
`define CRV_CFG_STEP 24'h000002

// Instruction opcode patterns
`define CRV_OP_GOTO 8'h04
`define CRV_OP_MOVLIT 4'h2
`define CRV_OP_MOVWF 5'h11
`define CRV_OP_TABLE_READ_LOW 10'h2E8
`define CRV_MODE_IND 3'h1
`define CRV_MODE_POSTINC 3'h3

// Reset values, parameter defaults and the code-protect bit index
`define CRV_WORD_RESET 16'h0000
`define CRV_PAGE_RESET 8'h00
`define CRV_CFG_DEFAULT 16'hFFFF
`define CRV_CP_BIT 4'hF
`define CRV_SIG_DEFAULT 16'h005A

`endif

// ---- config_readback_pkg.sv ----
// Types shared by the configuration readback port
package config_readback_pkg;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_EXEC = 2'b01,
    ST_OUT = 2'b10,
    ST_SKIP = 2'b11
  } port_state_e;

endpackage

// ---- config_store.sv ----
// Configuration words, executive signature word and read protection
`timescale 1ns/100ps
`include "config_readback_consts.svh"

module config_store #(
  parameter logic [15:0] CW_FIRST = `CRV_CFG_DEFAULT,
  parameter logic [15:0] CW_SECOND = `CRV_CFG_DEFAULT,
  parameter logic [15:0] CW_THIRD = `CRV_CFG_DEFAULT,
  parameter logic [15:0] CW_FOURTH = `CRV_CFG_DEFAULT,
  // Arbitrary value standing for the resident-executive signature
  parameter logic [15:0] SIGNATURE = `CRV_SIG_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Read port
  input wire logic [23:0] rd_addr,
  output logic [23:0] rd_word,
  output logic read_protected
);

  logic armed_reg;
  logic armed_next;
  logic protect_reg;
  logic protect_next;

  // Configuration words sit in ascending order fourth, third, second, first
  function automatic logic [23:0] lookup(input logic [23:0] a);
    logic [23:0] w;
    w = 24'h000000;
    if (a == `CRV_CFG_BASE)
      w = {8'h00, CW_FOURTH};
    else if (a == `CRV_CFG_BASE + `CRV_CFG_STEP)
      w = {8'h00, CW_THIRD};
    else if (a == `CRV_CFG_BASE + 24'h000004)
      w = {8'h00, CW_SECOND};
    else if (a == `CRV_CFG_BASE + 24'h000006)
      w = {8'h00, CW_FIRST};
    else if (a == `CRV_SIG_ADDR)
      w = {8'h00, SIGNATURE};
    return w;
  endfunction

  // Protection is caught once, on the first edge after reset release
  always_comb
  begin
    armed_next = 1'b1;
    protect_next = protect_reg;
    if (!armed_reg)
      protect_next = ~CW_FIRST[`CRV_CP_BIT];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      armed_reg <= 1'b0;
      protect_reg <= 1'b0;
    end
    else
    begin
      armed_reg <= armed_next;
      protect_reg <= protect_next;
    end
  end

  assign rd_word = protect_reg ? 24'h000000 : lookup(rd_addr);
  assign read_protected = protect_reg;

  cfg_upper_zero_a: assert property (@(posedge clk) disable iff (reset)
    rd_word[23:16] == 8'h00) else $error("upper byte of read word not zero");
  sig_word_a: assert property (@(posedge clk) disable iff (reset)
    (rd_addr == `CRV_SIG_ADDR && !protect_reg) |-> rd_word[15:0] == SIGNATURE)
    else $error("signature word not returned");
  protect_blank_a: assert property (@(posedge clk) disable iff (reset)
    protect_reg |-> rd_word == 24'h000000) else $error("protected read returned data");

endmodule

// ---- prog_link_model.sv ----
// Programmer side of the serial programming link: clocked frames, LSb first
`timescale 1ns/100ps

module prog_link_model (
  // System clock, used only to pace the link
  input wire logic clk,
  // Device side of the data pin
  input wire logic dev_out,
  input wire logic dev_oe,
  // Link pins
  output logic prog_clk,
  output logic pin
);
  logic host_d;
  logic host_en;

  // --------------------------------------------------------------
  // Pin resolution
  // --------------------------------------------------------------
  // A released pin shows the inverse of the last host value, so a device
  // that forgets to drive cannot pass by luck
  assign pin = dev_oe ? dev_out : (host_en ? host_d : ~host_d);

  initial
  begin
    prog_clk = 1'b0;
    host_d = 1'b0;
    host_en = 1'b1;
  end

  // --------------------------------------------------------------
  // Bit timing
  // --------------------------------------------------------------
  // 80 ns link period; the clock stands low between frames
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // Data changes while the clock is low and is sampled just before the rise
  task automatic clock_bit(input logic en, input logic d, output logic s);
    host_en = en;
    if (en)
      host_d = d;
    half();
    s = pin;
    prog_clk = 1'b1;
    half();
    prog_clk = 1'b0;
  endtask

  // --------------------------------------------------------------
  // Frames
  // --------------------------------------------------------------
  // Four-bit code then a 24-bit payload, all LSb first
  task automatic send(input logic [3:0] code, input logic [23:0] payload);
    logic s;
    for (int i = 0; i < 4; i++)
      clock_bit(1'b1, code[i], s);
    for (int i = 0; i < 24; i++)
      clock_bit(1'b1, payload[i], s);
    half();
  endtask

  // Code 0001, then 16 bits clocked out of the device with the pin released
  task automatic readout(output logic [15:0] got);
    logic s;
    for (int i = 0; i < 4; i++)
      clock_bit(1'b1, i == 0, s);
    for (int i = 0; i < 16; i++)
    begin
      clock_bit(1'b0, 1'b0, s);
      got[i] = s;
    end
    half();
    half();
    host_en = 1'b1;
  endtask
endmodule

// ---- test_config_word_readback_verify.sv ----
// Self-checking bench for the configuration word readback port
`timescale 1ns/100ps

module test_config_word_readback_verify;
  localparam logic [15:0] WORD_FIRST = 16'hC3A5;
  localparam logic [15:0] WORD_SECOND = 16'h5A96;
  localparam logic [15:0] WORD_THIRD = 16'h0F1E;
  localparam logic [15:0] WORD_FOURTH = 16'h7E81;
  // Arbitrary signature value
  localparam logic [15:0] SIG = 16'h00A7;

  logic clk;
  logic reset;
  logic prog_clk;
  logic pin;
  logic prog_data_out;
  logic prog_data_oe;
  logic [15:0] serial_visibility_out;
  logic [15:0] exec_pc;
  logic read_protected;
  logic [15:0] locked_vis;
  logic locked_protected;
  int n_fail;
  int n_compared;
  logic [15:0] cw_exp [4];

  // --------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------
  config_word_readback_verify #(.CW_FIRST(WORD_FIRST), .CW_SECOND(WORD_SECOND),
    .CW_THIRD(WORD_THIRD), .CW_FOURTH(WORD_FOURTH), .SIGNATURE(SIG))
    config_word_readback_verify_i (
    .clk(clk), .reset(reset), .prog_clk(prog_clk), .prog_data_in(pin),
    .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
    .serial_visibility_out(serial_visibility_out), .exec_pc(exec_pc),
    .read_protected(read_protected));

  // Same link traffic, code-protect bit cleared: only listens
  config_word_readback_verify #(.CW_FIRST(16'h43A5), .CW_SECOND(WORD_SECOND),
    .CW_THIRD(WORD_THIRD), .CW_FOURTH(WORD_FOURTH), .SIGNATURE(SIG))
    locked_config_word_readback_verify_i (
    .clk(clk), .reset(reset), .prog_clk(prog_clk), .prog_data_in(pin),
    .prog_data_out(), .prog_data_oe(), .serial_visibility_out(locked_vis),
    .exec_pc(), .read_protected(locked_protected));

  prog_link_model prog_link_model_i (.clk(clk), .dev_out(prog_data_out),
    .dev_oe(prog_data_oe), .prog_clk(prog_clk), .pin(pin));

  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic ex(input logic [23:0] ins);
    prog_link_model_i.send(4'h0, ins);
  endtask

  task automatic rd(input logic [15:0] exp);
    logic [15:0] got;
    prog_link_model_i.readout(got);
    check16(got, exp);
    check16({15'h0000, prog_data_oe}, 16'h0000);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    reset = 1'b1;
    cw_exp = '{WORD_FOURTH, WORD_THIRD, WORD_SECOND, WORD_FIRST};
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check16({15'h0000, read_protected}, 16'h0000);
    check16({15'h0000, locked_protected}, 16'h0001);
    check16(serial_visibility_out, 16'h0000);
    ex(24'h000000);
    ex(24'h040200);
    ex(24'h000000);
    check16(exec_pc, 16'h0200);
    ex(24'h200000);
    ex(24'h880190);
    ex(24'h201006);
    ex(24'h207847);
    ex(24'h000000);
    // Fourth word first, then third, second, first
    for (int k = 0; k < 4; k++)
    begin
      ex(24'hBA0BB6);
      ex(24'h000000);
      ex(24'h000000);
      check16(serial_visibility_out, cw_exp[k]);
      check16(locked_vis, 16'h0000);
      rd(cw_exp[k]);
      ex(24'h000000);
    end
    ex(24'h040344);
    check16(exec_pc, 16'h0344);
    ex(24'h040200);
    ex(24'h000000);
    check16(exec_pc, 16'h0200);
    ex(24'h200800);
    ex(24'h880190);
    ex(24'h207F00);
    ex(24'h207841);
    ex(24'h000000);
    ex(24'hBA0890);
    ex(24'h000000);
    ex(24'h000000);
    check16(locked_vis, 16'h0000);
    rd(SIG);
    ex(24'h000000);
    // Unknown code: payload consumed, nothing executed
    prog_link_model_i.send(4'h5, 24'h040344);
    check16(exec_pc, 16'h0200);
    rd(SIG);
    end_sim();
  end
endmodule
